// ==== pkg/rfes_pkg.sv ====
// Shared constants and types for the router fault and emergency stage
package rfes_pkg;
    // Packet layout
    localparam int PKT_W       = 72;
    localparam int TYPE_LSB    = 0;
    localparam int TYPE_W      = 3;
    localparam int PHASE_LSB   = 3;
    localparam int PHASE_W     = 2;
    localparam int PARITY_BIT  = 5;
    // Destination vector: links then local processors
    localparam int NUM_LINKS   = 6;
    localparam int NUM_PROCS   = 20;
    localparam int DEST_W      = NUM_LINKS + NUM_PROCS;
    localparam int FIFO_DEPTH  = 8;
    localparam int MONITOR_W   = 5;
    // Packet type codes
    localparam logic [2:0] TYPE_MC       = 3'h0;
    localparam logic [2:0] TYPE_P2P      = 3'h1;
    localparam logic [2:0] TYPE_EMG_FWD  = 3'h4;
    localparam logic [2:0] TYPE_EMG_DUAL = 3'h5;
    // Age at which a packet expires, in phases
    localparam logic [1:0] EXPIRE_AGE    = 2'h2;
    // Time in ns a full indication must persist before a link counts as blocked
    localparam int BLOCK_NS    = 64;
    localparam int CLK_NS      = 4;
    localparam int BLOCK_CYC   = (BLOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] BLOCK_CYC_W = 8'(BLOCK_CYC);
    // Reset values
    localparam logic [NUM_LINKS-1:0] LINKS_RST = '0;
    typedef enum logic [1:0] {RFES_IDLE, RFES_OUT} rfes_state_t;
endpackage

// ==== src/rfes_fifo.sv ====
// Small FIFO holding outgoing routed packets
`timescale 1ns/1ns
module rfes_fifo
    import rfes_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // Handshakes
    assign count    = wr_ptr - rd_ptr;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    // Head slot after this cycle's pop
    assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

    // Storage write
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    // Pointers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Registered read port, first-word presented when not empty
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            if (!out_valid || out_ready)
            begin
                out_valid <= (wr_ptr != next_rd_ptr);
                out_data  <= mem[next_rd_ptr[AW-1:0]];
            end
        end
    end
endmodule

// ==== src/rfes_stage.sv ====
// Router fault handling and emergency diversion stage
`timescale 1ns/1ns
module rfes_stage
    import rfes_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // Packet from arbiter
    input  wire logic                 pkt_valid,
    output logic                      pkt_ready,
    input  wire logic [PKT_W-1:0]     pkt_data,
    input  wire logic                 pkt_local,
    input  wire logic [2:0]           pkt_rx_link,
    // Global time phase and monitor identity
    input  wire logic [PHASE_W-1:0]   time_phase,
    input  wire logic [MONITOR_W-1:0] monitor_id,
    // Routing engine results
    output logic                      mc_lookup_en,
    output logic                      alg_lookup_en,
    input  wire logic                 mc_hit,
    input  wire logic [DEST_W-1:0]    mc_dest,
    input  wire logic [DEST_W-1:0]    alg_dest,
    // Output buffer feedback and link reset
    input  wire logic [NUM_LINKS-1:0] link_full,
    input  wire logic [NUM_LINKS-1:0] link_reset,
    // Fault induction
    input  wire logic                 inject_parity,
    input  wire logic                 inject_age,
    input  wire logic                 inject_unroutable,
    input  wire logic [NUM_LINKS-1:0] inject_block,
    // Routed packet out
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [PKT_W-1:0]          out_data,
    output logic [DEST_W-1:0]         out_dest,
    // Monitor reporting
    output logic [NUM_LINKS-1:0]      link_blocked,
    output logic                      err_parity,
    output logic                      err_expired,
    output logic                      err_unroutable
);
    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [NUM_LINKS-1:0] rot(input logic [NUM_LINKS-1:0] v, input int n);
        logic [2*NUM_LINKS-1:0] d;
        d = {v, v} << n;
        return d[2*NUM_LINKS-1:NUM_LINKS];
    endfunction

    logic [NUM_LINKS-1:0] blk_cnt_hit;
    logic [7:0]           blk_cnt [NUM_LINKS];
    logic [NUM_LINKS-1:0] blocked_eff;
    logic [PKT_W-1:0]     pkt_fix;
    logic [2:0]           ptype;
    logic                 par_bad;
    logic                 expired;
    logic                 unroutable;
    logic [DEST_W-1:0]    next_dest;
    logic [TYPE_W-1:0]    next_type;
    logic [NUM_LINKS-1:0] norm_links;
    logic [NUM_LINKS-1:0] keep_links;
    logic [NUM_LINKS-1:0] div_links;
    logic [DEST_W-1:0]    monitor_vec;
    logic                 stage_valid;
    logic                 stage_ready;
    logic [PKT_W+DEST_W-1:0] stage_word;
    logic [PKT_W+DEST_W-1:0] fifo_word;

    ////////////////////////////////////////////////////////////////////
    // Blocked link detection per link
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_LINKS; i++)
                blk_cnt[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_LINKS; i++)
                if (link_reset[i] || !link_full[i])
                    blk_cnt[i] <= '0;
                else if (blk_cnt[i] != BLOCK_CYC_W)
                    blk_cnt[i] <= blk_cnt[i] + 8'h01;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_LINKS; i++)
            blk_cnt_hit[i] = (blk_cnt[i] == BLOCK_CYC_W);
    end
    assign blocked_eff = blk_cnt_hit | inject_block;

    // Report blockage to monitor
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            link_blocked <= LINKS_RST;
        else
            link_blocked <= blocked_eff & ~link_reset;
    end

    ////////////////////////////////////////////////////////////////////
    // Error checks on the incoming packet
    always_comb
    begin
        pkt_fix = pkt_data;
        if (pkt_local)
            pkt_fix[PHASE_LSB +: PHASE_W] = time_phase;
        if (pkt_local)
            pkt_fix[PARITY_BIT] = pkt_data[PARITY_BIT] ^ (^pkt_data[PHASE_LSB +: PHASE_W]) ^ (^time_phase);
    end
    assign ptype      = pkt_fix[TYPE_LSB +: TYPE_W];
    assign par_bad    = (^pkt_fix) ^ inject_parity;
    assign expired    = (PHASE_W'(time_phase - pkt_fix[PHASE_LSB +: PHASE_W]) == EXPIRE_AGE)
                        || inject_age;
    assign mc_lookup_en  = pkt_valid && !par_bad && !expired && ptype == TYPE_MC;
    assign alg_lookup_en = pkt_valid;
    assign unroutable = mc_lookup_en && ((pkt_local && !mc_hit) || inject_unroutable);
    assign monitor_vec = DEST_W'(1) << (NUM_LINKS + int'(monitor_id));

    ////////////////////////////////////////////////////////////////////
    // Destination selection and emergency diversion
    always_comb
    begin
        next_type  = ptype;
        next_dest  = (mc_lookup_en && mc_hit) ? mc_dest : alg_dest;
        norm_links = next_dest[NUM_LINKS-1:0];
        keep_links = norm_links & ~blocked_eff;
        div_links  = '0;
        for (int i = 0; i < NUM_LINKS; i++)
            if (norm_links[i] && blocked_eff[i])
                div_links = div_links | rot(NUM_LINKS'(1 << i), 1); // first edge
        if (par_bad || expired || unroutable)
            next_dest = monitor_vec;
        else
        begin
            next_dest[NUM_LINKS-1:0] = keep_links | div_links;
            if (ptype == TYPE_MC && div_links != '0)
                next_type = ((keep_links & div_links) != '0) ? TYPE_EMG_DUAL : TYPE_EMG_FWD;
            else if (ptype == TYPE_EMG_FWD)
                next_dest[NUM_LINKS-1:0] = rot(NUM_LINKS'(1 << pkt_rx_link), 3); // default onward
        end
    end

    assign stage_valid = pkt_valid;
    assign pkt_ready   = stage_ready;
    // Type rewrite also corrects parity so neighbours see a clean packet
    assign stage_word  = {pkt_fix[PKT_W-1:PARITY_BIT+1],
                          pkt_fix[PARITY_BIT] ^ (^(ptype ^ next_type)),
                          pkt_fix[PARITY_BIT-1:TYPE_W], next_type, next_dest};

    ////////////////////////////////////////////////////////////////////
    // Error flags, one-cycle pulses per accepted packet
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            err_parity     <= 1'b0;
            err_expired    <= 1'b0;
            err_unroutable <= 1'b0;
        end
        else
        begin
            err_parity     <= pkt_valid && stage_ready && par_bad;
            err_expired    <= pkt_valid && stage_ready && expired && !par_bad;
            err_unroutable <= pkt_valid && stage_ready && unroutable && !par_bad && !expired;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output buffer
    rfes_fifo #(
        .WIDTH (PKT_W + DEST_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (stage_valid),
        .in_ready  (stage_ready),
        .in_data   (stage_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_word)
    );

    // Outputs taken straight from the buffer's head register
    assign out_data = fifo_word[PKT_W+DEST_W-1:DEST_W];
    assign out_dest = fifo_word[DEST_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_err_mon;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && stage_ready && par_bad) |=> err_parity;
    endproperty
    a_err_mon: assert property (p_err_mon) else $error("parity error not reported");

    property p_exp;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && expired && !par_bad) |-> (next_dest == monitor_vec);
    endproperty
    a_exp: assert property (p_exp) else $error("expired packet not to monitor");

    property p_blk;
        @(posedge clock) disable iff (sys_rst)
        (link_full[1] && !link_reset[1])[*8] ##1 (link_full[1] && !link_reset[1])[*8]
            ##1 (link_full[1] && !link_reset[1]) |=> link_blocked[1];
    endproperty
    a_blk: assert property (p_blk) else $error("blockage not reported");

    property p_rst;
        @(posedge clock) disable iff (sys_rst)
        link_reset[1] |=> !link_blocked[1];
    endproperty
    a_rst: assert property (p_rst) else $error("link reset ignored");

    property p_mc;
        @(posedge clock) disable iff (sys_rst)
        mc_lookup_en |-> (!par_bad && !expired && ptype == TYPE_MC);
    endproperty
    a_mc: assert property (p_mc) else $error("lookup on bad packet");

    property p_p2p;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && ptype == TYPE_P2P) |-> (next_type == TYPE_P2P);
    endproperty
    a_p2p: assert property (p_p2p) else $error("p2p type changed");

    property p_div;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && !par_bad && !expired && !unroutable && ptype == TYPE_MC)
            |-> ((next_dest[NUM_LINKS-1:0] & blocked_eff) == '0);
    endproperty
    a_div: assert property (p_div) else $error("blocked link used");

    property p_unr;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && stage_ready && unroutable && !par_bad && !expired) |=> err_unroutable;
    endproperty
    a_unr: assert property (p_unr) else $error("unroutable not reported");

    property p_stamp;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && pkt_local) |-> (pkt_fix[PHASE_LSB +: PHASE_W] == time_phase) && ((^pkt_fix) == (^pkt_data));
    endproperty
    a_stamp: assert property (p_stamp) else $error("local phase not stamped");

    property p_inj;
        @(posedge clock) disable iff (sys_rst)
        (inject_block[3] && !link_reset[3]) |=> link_blocked[3];
    endproperty
    a_inj: assert property (p_inj) else $error("induced blockage not reported");

    property p_emg;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && !par_bad && !expired && !unroutable && ptype == TYPE_MC && div_links != '0)
            |-> (next_type == TYPE_EMG_FWD || next_type == TYPE_EMG_DUAL);
    endproperty
    a_emg: assert property (p_emg) else $error("diverted packet not emergency");

    property p_dual;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && !par_bad && !expired && !unroutable && ptype == TYPE_MC && (keep_links & div_links) != '0)
            |-> (next_type == TYPE_EMG_DUAL);
    endproperty
    a_dual: assert property (p_dual) else $error("shared link not merged");

    property p_age;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && !pkt_local && !inject_age)
            |-> (expired == (PHASE_W'(pkt_data[PHASE_LSB +: PHASE_W] + EXPIRE_AGE) == time_phase));
    endproperty
    a_age: assert property (p_age) else $error("age judged wrongly");

    property p_par_route;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && par_bad) |-> (next_dest == monitor_vec);
    endproperty
    a_par_route: assert property (p_par_route) else $error("parity packet not to monitor");

    property p_unr_route;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && pkt_local && mc_lookup_en && !mc_hit) |-> (unroutable && next_dest == monitor_vec);
    endproperty
    a_unr_route: assert property (p_unr_route) else $error("unroutable packet not to monitor");

    property p_fwd;
        @(posedge clock) disable iff (sys_rst)
        (pkt_valid && ptype == TYPE_EMG_FWD && !par_bad && !expired)
            |-> (next_dest[NUM_LINKS-1:0] == NUM_LINKS'(1 << ((int'(pkt_rx_link) + 3) % NUM_LINKS)));
    endproperty
    a_fwd: assert property (p_fwd) else $error("emergency packet not sent onward");

    c_par: cover property (@(posedge clock) disable iff (sys_rst) err_parity);
    c_fwd: cover property (@(posedge clock) disable iff (sys_rst) pkt_valid && next_type == TYPE_EMG_FWD);
    c_blk: cover property (@(posedge clock) disable iff (sys_rst) link_blocked != '0);
    c_dual: cover property (@(posedge clock) disable iff (sys_rst) pkt_valid && next_type == TYPE_EMG_DUAL);
endmodule

// ==== bench/rfes_partner.sv ====
// Behavioural routing engines and output drain facing the fault stage
`timescale 1ns/1ns
module rfes_partner
    import rfes_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // Engine requests from the stage
    input  wire logic              mc_lookup_en,
    input  wire logic              alg_lookup_en,
    input  wire logic [2:0]        pkt_rx_link,
    // Bench controls
    input  wire logic              table_miss,
    input  wire logic [DEST_W-1:0] table_route,
    input  wire logic              drain_stall,
    // Engine answers and drain
    output logic                   mc_hit,
    output logic [DEST_W-1:0]      mc_dest,
    output logic [DEST_W-1:0]      alg_dest,
    output logic                   out_ready
);
    logic [DEST_W-1:0] junk;

    ////////////////////////////////////////////////////////////
    // Changing filler so idle answers never look stable
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            junk <= 26'h2aaaaaa;
        else
            junk <= ~junk;
    end

    // Answers only while the engine is enabled
    always_comb
    begin
        mc_hit   = mc_lookup_en ? !table_miss : junk[0];
        mc_dest  = (mc_lookup_en && !table_miss) ? table_route : junk;
        alg_dest = junk;
        if (alg_lookup_en)
            alg_dest = DEST_W'(1) << (({1'b0, pkt_rx_link} + 4'h3) % 4'h6);
    end

    // Drain takes words unless stalled
    assign out_ready = !drain_stall;
endmodule

// ==== bench/rfes_stage_test.sv ====
// Self-checking bench for the fault and emergency stage
`timescale 1ns/1ns
module rfes_stage_test
    import rfes_pkg::*;
;
    logic                 clock, sys_rst, pkt_valid, pkt_ready, pkt_local, mc_hit, out_valid, out_ready;
    logic                 mc_lookup_en, alg_lookup_en, inject_parity, inject_age, inject_unroutable;
    logic                 err_parity, err_expired, err_unroutable, table_miss, drain_stall;
    logic                 s_par, s_exp, s_unr, mc_en, alg_en;
    logic [PKT_W-1:0]     pkt_data, out_data, last;
    logic [2:0]           pkt_rx_link;
    logic [PHASE_W-1:0]   time_phase;
    logic [MONITOR_W-1:0] monitor_id;
    logic [DEST_W-1:0]    mc_dest, alg_dest, out_dest, table_route, mon;
    logic [NUM_LINKS-1:0] link_full, link_reset, inject_block, link_blocked;
    logic [PKT_W-1:0]     q_data[$];
    logic [DEST_W-1:0]    q_dest[$];
    int                   fail_count, num_checks, cycles, seq, n_in;

    rfes_stage dut (.clock, .sys_rst, .pkt_valid, .pkt_ready, .pkt_data, .pkt_local, .pkt_rx_link,
        .time_phase, .monitor_id, .mc_lookup_en, .alg_lookup_en, .mc_hit, .mc_dest, .alg_dest,
        .link_full, .link_reset, .inject_parity, .inject_age, .inject_unroutable, .inject_block,
        .out_valid, .out_ready, .out_data, .out_dest, .link_blocked, .err_parity, .err_expired,
        .err_unroutable);
    rfes_partner far (.clock, .sys_rst, .mc_lookup_en, .alg_lookup_en, .pkt_rx_link, .table_miss,
        .table_route, .drain_stall, .mc_hit, .mc_dest, .alg_dest, .out_ready);

    ////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        clock = 0;
        forever #2 clock = ~clock;
    end

    // Capture outputs, lookups, error pulses; cut hangs
    always @(posedge clock)
    begin
        cycles++;
        if (out_valid && out_ready)
        begin
            q_data.push_back(out_data);
            q_dest.push_back(out_dest);
        end
        if (pkt_valid && pkt_ready)
        begin
            mc_en = mc_lookup_en;
            alg_en = alg_lookup_en;
            n_in++;
        end
        s_par |= err_parity;
        s_exp |= err_expired;
        s_unr |= err_unroutable;
        if (cycles > 20000)
        begin
            fail_count++;
            wrap_up;
        end
    end

    ////////////////////////////////////////////////////////////
    task wrap_up;
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [PKT_W-1:0] act, input logic [PKT_W-1:0] exp, input string m);
        num_checks++;
        if (act !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // Packet with even parity unless spoiled
    function automatic logic [PKT_W-1:0] mk(input logic [2:0] ty, input logic [1:0] ph, input logic bad);
        logic [PKT_W-1:0] p;
        p = {50'(seq), 16'h0, 1'b0, ph, ty};
        p[PARITY_BIT] = (^p) ^ bad;
        return p;
    endfunction

    task send(input logic [2:0] ty, input logic [1:0] ph, input logic bad, input logic loc,
              input logic [2:0] rx);
        int n;
        seq++;
        s_par = 0;
        s_exp = 0;
        s_unr = 0;
        @(negedge clock);
        pkt_data = mk(ty, ph, bad);
        pkt_local = loc;
        pkt_rx_link = rx;
        pkt_valid = 1;
        n = 0;
        while (!pkt_ready && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        pkt_valid = 0;
    endtask

    task take(input logic [DEST_W-1:0] d, input logic [2:0] ty, input string m);
        int n;
        n = 0;
        while (q_dest.size() == 0 && n < 60)
        begin
            @(negedge clock);
            n++;
        end
        if (q_dest.size() == 0)
            chk(1, 0, m);
        else
        begin
            last = q_data.pop_front();
            chk(q_dest.pop_front(), d, m);
            chk(last[2:0], ty, m);
        end
    endtask

    task flush;
        repeat (30) @(negedge clock);
        q_data.delete();
        q_dest.delete();
    endtask

    ////////////////////////////////////////////////////////////
    task t_errors;
        send(TYPE_MC, 2'h0, 0, 0, 3'h0);
        take(table_route, TYPE_MC, "clean route");
        chk({s_par, s_exp, mc_en, alg_en}, 4'h3, "clean lookups");
        send(TYPE_MC, 2'h0, 1, 0, 3'h0);
        take(mon, TYPE_MC, "parity route");
        chk({s_par, mc_en, alg_en}, 3'h5, "parity lookups");
        time_phase = 2'h1;
        send(TYPE_MC, 2'h3, 0, 0, 3'h0);
        take(mon, TYPE_MC, "expired route");
        chk(s_exp, 1, "expiry wrap");
        send(TYPE_MC, 2'h0, 0, 0, 3'h0);
        take(table_route, TYPE_MC, "age one route");
        chk(s_exp, 0, "age one flag");
        send(TYPE_EMG_FWD, 2'h0, 0, 0, 3'h1);
        take(26'h10, TYPE_EMG_FWD, "emergency onward");
        chk(mc_en, 0, "no lookup on emergency");
    endtask

    task t_local;
        time_phase = 2'h2;
        send(TYPE_MC, 2'h0, 0, 1, 3'h0);
        take(table_route, TYPE_MC, "local route");
        chk(last[4:3], 2'h2, "phase stamp");
        chk(^last, 0, "stamp parity");
        table_miss = 1;
        send(TYPE_MC, 2'h0, 0, 1, 3'h0);
        flush;
        chk(s_unr, 1, "local miss");
        send(TYPE_MC, 2'h2, 0, 0, 3'h0);
        take(26'h8, TYPE_MC, "default route");
        chk(s_unr, 0, "remote miss");
        table_miss = 0;
        time_phase = 2'h0;
    endtask

    task t_block;
        link_full = 6'h02;
        repeat (8) @(negedge clock);
        chk(link_blocked, 6'h00, "early block");
        repeat (20) @(negedge clock);
        chk(link_blocked, 6'h02, "blocked");
        send(TYPE_MC, 2'h0, 0, 0, 3'h0);
        take(26'h104, TYPE_EMG_FWD, "divert");
        chk(^last, 0, "divert parity");
        table_route = 26'h106;
        send(TYPE_MC, 2'h0, 0, 0, 3'h0);
        take(26'h104, TYPE_EMG_DUAL, "merged");
        table_route = 26'h102;
        send(TYPE_P2P, 2'h0, 0, 0, 3'h4);
        take(26'h4, TYPE_P2P, "p2p divert");
        link_reset = 6'h02;
        @(negedge clock);
        link_reset = 6'h00;
        repeat (3) @(negedge clock);
        chk(link_blocked, 6'h00, "link reset");
        link_full = 6'h00;
    endtask

    task t_inject;
        for (int k = 0; k < 3; k++)
        begin
            {inject_parity, inject_age, inject_unroutable} = 3'h4 >> k;
            send(TYPE_MC, 2'h0, 0, 0, 3'h0);
            flush;
            chk({s_par, s_exp, s_unr}, 3'h4 >> k, "induced error");
        end
        {inject_parity, inject_age, inject_unroutable} = 3'h0;
        inject_block = 6'h08;
        repeat (30) @(negedge clock);
        chk(link_blocked, 6'h08, "induced block");
        inject_block = 6'h00;
        link_reset = 6'h08;
        @(negedge clock);
        link_reset = 6'h00;
    endtask

    task t_fifo;
        drain_stall = 1;
        n_in = 0;
        pkt_data = mk(TYPE_MC, 2'h0, 0);
        pkt_valid = 1;
        repeat (20) @(negedge clock);
        chk(n_in, FIFO_DEPTH, "fill count");
        chk(pkt_ready, 0, "refused");
        pkt_valid = 0;
        repeat (40)
        begin
            drain_stall = ~drain_stall;
            @(negedge clock);
        end
        drain_stall = 0;
        repeat (10) @(negedge clock);
        chk(q_dest.size(), FIFO_DEPTH, "drain count");
        chk(out_valid, 0, "empty");
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst = 1;
        {pkt_valid, pkt_local, table_miss, drain_stall} = 4'h0;
        {inject_parity, inject_age, inject_unroutable} = 3'h0;
        pkt_data = '0;
        pkt_rx_link = 3'h0;
        time_phase = 2'h0;
        monitor_id = 5'h03;
        mon = 26'h200;
        link_full = 6'h00;
        link_reset = 6'h00;
        inject_block = 6'h00;
        table_route = 26'h102;
        {fail_count, num_checks, cycles, seq, n_in} = '0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        sys_rst = 0;
        t_errors;
        t_local;
        t_block;
        t_inject;
        t_fifo;
        wrap_up;
    end
endmodule
